/* rtl/current_sample_pwm_encoder.sv */
module current_sample_pwm_encoder import cspwm_pkg::*; #(
  parameter int unsigned HALF_STEP_CYC_P = HALF_STEP_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // filtered current samples
  input wire logic signed [SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid_in,
  // pwm output and status
  output logic pwm_out,
  output logic [DUTY_W-1:0] duty_code_out,
  output logic slot_strobe_out
);
  typedef struct packed {
    logic [CYC_W-1:0] cyc;
    logic [HALF_W-1:0] half;
    logic signed [ACC_W-1:0] acc;
    logic [CNT_W-1:0] cnt;
    logic signed [SAMPLE_W-1:0] avg;
    logic [DUTY_W-1:0] duty;
    logic pwm;
    logic slot_stb;
    logic div_start;
    logic signed [ACC_W-1:0] div_dividend;
    logic [CNT_W-1:0] div_divisor;
  } enc_s;

  enc_s st_q, st_d;
  avg_div_if div_bus ();

  logic last_cyc;
  logic last_half;
  logic wrap;
  logic close;
  logic signed [ACC_W-1:0] acc_next;
  logic [CNT_W-1:0] cnt_next;

  // window closes DIV_LAT cycles before the wrap, for any half-step length
  localparam int unsigned CLOSE_POS =
    HALF_STEPS * HALF_STEP_CYC_P - 1 - DIV_LAT;
  localparam int unsigned CLOSE_HALF = CLOSE_POS / HALF_STEP_CYC_P;
  localparam int unsigned CLOSE_CYC = CLOSE_POS % HALF_STEP_CYC_P;

  // average code to duty step, clamped to full scale
  function automatic logic [DUTY_W-1:0] duty_map(
    input logic signed [SAMPLE_W-1:0] s
  );
    logic signed [SAMPLE_W-1:0] c;
    logic signed [23:0] p;
    c = s;
    if (s > FS_CODE) begin
      c = FS_CODE;
    end else if (s < -FS_CODE) begin
      c = -FS_CODE;
    end
    p = 24'(c) * $signed({14'h0000, SPAN_CODE});
    return DUTY_W'($signed({1'b0, MID_CODE}) + (p >>> SPAN_SHIFT));
  endfunction

  always_comb begin
    st_d = st_q;
    last_cyc = st_q.cyc == CYC_W'(HALF_STEP_CYC_P - 1);
    last_half = st_q.half == HALF_W'(HALF_STEPS - 1);
    wrap = last_cyc && last_half;
    // window closes early so the divider finishes before the wrap
    close = st_q.half == HALF_W'(CLOSE_HALF) &&
            st_q.cyc == CYC_W'(CLOSE_CYC);
    acc_next = st_q.acc;
    cnt_next = st_q.cnt;
    if (sample_valid_in) begin
      acc_next = st_q.acc + ACC_W'(sample_in);
      cnt_next = st_q.cnt + CNT_W'(1);
    end
    // half-step timebase, 2048 half steps per period
    st_d.cyc = last_cyc ? '0 : st_q.cyc + CYC_W'(1);
    if (last_cyc) begin
      st_d.half = st_q.half + HALF_W'(1);
    end
    st_d.acc = acc_next;
    st_d.cnt = cnt_next;
    st_d.div_start = 1'b0;
    if (close) begin
      st_d.div_start = cnt_next != '0;
      st_d.div_dividend = acc_next;
      st_d.div_divisor = cnt_next;
      st_d.acc = '0;
      st_d.cnt = '0;
    end
    if (div_bus.done) begin
      st_d.avg = div_bus.quotient[SAMPLE_W-1:0];
    end
    st_d.slot_stb = wrap;
    if (wrap) begin
      st_d.duty = duty_map(st_q.avg);
    end
    // high for 2N+1 half steps: N steps plus the extra half
    st_d.pwm = st_q.half < {st_q.duty, 1'b1};
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= '0;
      st_q.duty <= MID_CODE;
    end else begin
      st_q <= st_d;
    end
  end

  assign div_bus.start = st_q.div_start;
  assign div_bus.dividend = st_q.div_dividend;
  assign div_bus.divisor = st_q.div_divisor;

  sample_avg_div u_div (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .div(div_bus.srv)
  );

  assign pwm_out = st_q.pwm;
  assign duty_code_out = st_q.duty;
  assign slot_strobe_out = st_q.slot_stb;

  a_duty_range: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    duty_code_out >= DUTY_MIN && duty_code_out <= DUTY_MAX)
    else $error("duty outside full scale");

  a_duty_at_wrap: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !wrap |=> $stable(duty_code_out))
    else $error("duty changed inside an interval");

  a_zero_mid: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (wrap && st_q.avg == '0) |=> duty_code_out == 10'h200)
    else $error("zero current not at half duty");

  a_pos_full: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (wrap && st_q.avg >= FS_CODE) |=> duty_code_out == 10'h3D2)
    else $error("positive full scale duty wrong");

  a_neg_full: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (wrap && st_q.avg <= -FS_CODE) |=> duty_code_out == 10'h02E)
    else $error("negative full scale duty wrong");

  a_half_step_high: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (st_q.half == {st_q.duty, 1'b0} && st_q.cyc == '0) |=> pwm_out)
    else $error("extra half step missing");

  a_pulse_end: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (st_q.half == {st_q.duty, 1'b1} && st_q.cyc == '0) |=> !pwm_out)
    else $error("pulse longer than N and a half");

  a_window_reset: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    close |=> st_q.cnt == '0 && st_q.acc == '0)
    else $error("averaging window not restarted");

  a_strobe_wrap: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    wrap |=> slot_strobe_out)
    else $error("strobe missing after wrap");

  a_strobe_single: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !wrap |=> !slot_strobe_out)
    else $error("strobe away from the wrap");

  a_strobe_base: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    slot_strobe_out |-> (st_q.half == '0 && st_q.cyc == '0))
    else $error("strobe not at period start");

  a_cyc_bound: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    st_q.cyc <= CYC_W'(HALF_STEP_CYC_P - 1))
    else $error("half step counter overran");

  a_half_advance: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    last_cyc |=> st_q.half == $past(st_q.half) + HALF_W'(1))
    else $error("half step did not advance");

  a_half_hold: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !last_cyc |=> $stable(st_q.half))
    else $error("half step moved early");

  a_pwm_rise: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (st_q.half == '0 && st_q.cyc == '0) |=> pwm_out)
    else $error("pulse did not start");

  a_wrap_pwm_low: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    wrap |=> !pwm_out)
    else $error("output high across the wrap");

  a_floor_high: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (st_q.half <= {DUTY_MIN, 1'b0}) |=> pwm_out)
    else $error("pulse below negative full scale");

  a_ceiling_low: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (st_q.half > {DUTY_MAX, 1'b0}) |=> !pwm_out)
    else $error("pulse above positive full scale");

  a_close_lead: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    close |-> ##40 wrap)
    else $error("window close not ahead of the wrap");

  a_start_count: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    div_bus.start |-> div_bus.divisor != '0)
    else $error("average started on an empty window");

  a_start_close: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (close && sample_valid_in) |=> div_bus.start)
    else $error("average not started at window close");

  a_avg_hold: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !div_bus.done |=> $stable(st_q.avg))
    else $error("average changed without a result");

  a_avg_load: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    div_bus.done |=> st_q.avg == $past(div_bus.quotient[SAMPLE_W-1:0]))
    else $error("average result not taken");

  a_acc_hold: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (!sample_valid_in && !close) |=> $stable(st_q.acc))
    else $error("sum moved without a sample");

  a_cnt_step: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (sample_valid_in && !close) |=> st_q.cnt == $past(st_q.cnt) + CNT_W'(1))
    else $error("sample count did not step");
endmodule // current_sample_pwm_encoder

/* rtl/cspwm_pkg.sv */
// Contract
// - The output has exactly 1024 duty steps per period, so duty moves only in 1/1024 increments.
// - For duty code N the output stays high for N and a half steps, a duty of (N + 0.5)/1024.
// - Duty maps linearly: positive full scale 95.5%, zero current 50%, negative full scale 4.5%.
// - Duty changes only at interval boundaries and carries the average of the interval just before, or the previous average if that interval had no samples.
// - Each sample is the average of the current over one fixed 50 ms slot; the code's interval is 999424 cycles, 49.9712 ms at 20 MHz.
package cspwm_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SLOT_MS = 50;
  localparam int unsigned SLOT_CYC = CLK_HZ / 1000 * SLOT_MS;
  localparam int unsigned DUTY_STEPS = 1024;
  localparam int unsigned HALF_STEPS = 2 * DUTY_STEPS;
  // 488 cycles per half step, period 999424 cycles
  localparam int unsigned HALF_STEP_CYC = SLOT_CYC / HALF_STEPS;
  localparam int unsigned SAMPLE_W = 13;
  localparam int unsigned ACC_W = 34;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned CYC_W = 12;
  localparam int unsigned HALF_W = 11;
  localparam int unsigned DUTY_W = 10;
  // divider answers ACC_W + 2 cycles after its start
  localparam int unsigned DIV_LAT = ACC_W + 6;
  localparam logic signed [SAMPLE_W-1:0] FS_CODE = 13'sh0800;
  localparam logic [DUTY_W-1:0] MID_CODE = 10'h200;
  localparam logic [DUTY_W-1:0] SPAN_CODE = 10'h1D2;
  localparam logic [DUTY_W-1:0] DUTY_MAX = MID_CODE + SPAN_CODE;
  localparam logic [DUTY_W-1:0] DUTY_MIN = MID_CODE - SPAN_CODE;
  localparam int unsigned SPAN_SHIFT = 11;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00,
    DIV_RUN = 2'b01,
    DIV_DONE = 2'b10
  } div_state_e;
endpackage

/* rtl/avg_div_if.sv */
interface avg_div_if import cspwm_pkg::*; ();
  logic start;
  logic signed [ACC_W-1:0] dividend;
  logic [CNT_W-1:0] divisor;
  logic done;
  logic signed [ACC_W-1:0] quotient;

  modport req (
    output start,
    output dividend,
    output divisor,
    input done,
    input quotient
  );
  modport srv (
    input start,
    input dividend,
    input divisor,
    output done,
    output quotient
  );
endinterface

/* rtl/sample_avg_div.sv */
module sample_avg_div import cspwm_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // request from the encoder
  avg_div_if.srv div
);
  typedef struct packed {
    div_state_e state;
    logic neg;
    logic [CNT_W-1:0] dvs;
    logic [CNT_W:0] rem;
    logic [ACC_W-1:0] quo;
    logic [5:0] iter;
    logic done;
    logic signed [ACC_W-1:0] result;
  } div_s;

  div_s st_q, st_d;
  logic [CNT_W:0] trial;

  // restoring division on magnitudes, sign restored at the end
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    trial = {st_q.rem[CNT_W-1:0], st_q.quo[ACC_W-1]};
    case (st_q.state)
      DIV_IDLE: begin
        if (div.start) begin
          st_d.state = DIV_RUN;
          st_d.neg = div.dividend[ACC_W-1];
          st_d.quo = div.dividend[ACC_W-1] ? ACC_W'(-div.dividend)
                                            : div.dividend;
          st_d.dvs = div.divisor;
          st_d.rem = '0;
          st_d.iter = '0;
        end
      end
      DIV_RUN: begin
        if (trial >= {1'b0, st_q.dvs}) begin
          st_d.rem = trial - {1'b0, st_q.dvs};
          st_d.quo = {st_q.quo[ACC_W-2:0], 1'b1};
        end else begin
          st_d.rem = trial;
          st_d.quo = {st_q.quo[ACC_W-2:0], 1'b0};
        end
        st_d.iter = st_q.iter + 6'h01;
        if (st_q.iter == 6'(ACC_W - 1)) begin
          st_d.state = DIV_DONE;
        end
      end
      DIV_DONE: begin
        st_d.done = 1'b1;
        st_d.result = st_q.neg ? ACC_W'(-st_q.quo) : st_q.quo;
        st_d.state = DIV_IDLE;
      end
      default: begin
        st_d.state = DIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign div.done = st_q.done;
  assign div.quotient = st_q.result;

  a_div_latency: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (div.start && st_q.state == DIV_IDLE) |-> ##36 div.done)
    else $error("average not ready in time");
endmodule // sample_avg_div

/* dv/pwm_meter.sv */
module pwm_meter #(
  parameter int unsigned H = 42,
  parameter int FS_MA = 1000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // measured line
  input wire logic pwm_in,
  // last full period seen
  output logic [31:0] high_out,
  output logic [31:0] per_out,
  output logic [31:0] code_out,
  // two-period average code, and current in mA from the last period's code
  output logic [31:0] avg2_out,
  output logic signed [31:0] ma_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] hc;
  logic [31:0] pc;
  logic last;
  logic [31:0] prev_high_q;
  // timer capture on each rising edge of the line
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hc <= 0;
      pc <= 0;
      last <= 1'b0;
      high_out <= 0;
      per_out <= 0;
      prev_high_q <= 0;
    end else begin
      last <= pwm_in;
      if (pwm_in && !last) begin
        high_out <= hc;
        prev_high_q <= high_out;
        per_out <= pc;
        hc <= 1;
        pc <= 1;
      end else begin
        hc <= hc + 32'(pwm_in);
        pc <= pc + 1;
      end
    end
  end
  // half step removed before turning duty into a code
  assign code_out = (high_out / H - 1) / 2;
  // readings of two periods averaged, half step taken off each
  assign avg2_out = ((high_out + prev_high_q) / H - 2) / 4;
  assign ma_out = 22 * FS_MA * ($signed(code_out) - 512) / 10240;
endmodule // pwm_meter

/* dv/current_sample_pwm_encoder_tb_top.sv */
module current_sample_pwm_encoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cspwm_pkg::*;
  localparam int unsigned H = 4;
  localparam int unsigned P = 2048 * H;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic signed [SAMPLE_W-1:0] sample_in = '0;
  logic sample_valid_in = 1'b0;
  logic pwm_out;
  logic [DUTY_W-1:0] duty_code_out;
  logic slot_strobe_out;
  logic [31:0] high_cyc, per_cyc, code_seen;
  logic [31:0] avg2_seen;
  logic signed [31:0] ma_seen;
  int errors = 0;
  int checked = 0;

  current_sample_pwm_encoder #(.HALF_STEP_CYC_P(H)) u_current_sample_pwm_encoder (
    .clk_in(clk_in), .nrst_in(nrst_in), .sample_in(sample_in),
    .sample_valid_in(sample_valid_in), .pwm_out(pwm_out),
    .duty_code_out(duty_code_out), .slot_strobe_out(slot_strobe_out));
  pwm_meter #(.H(H)) u_pwm_meter (.clk_in(clk_in), .nrst_in(nrst_in),
    .pwm_in(pwm_out), .high_out(high_cyc), .per_out(per_cyc),
    .code_out(code_seen), .avg2_out(avg2_seen), .ma_out(ma_seen));

  initial forever #25 clk_in = ~clk_in;

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // alternating samples, n of them back to back
  task automatic feed(int a, int b, int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      sample_in = SAMPLE_W'((i % 2) ? b : a);
      sample_valid_in = 1'b1;
    end
    @(negedge clk_in);
    sample_valid_in = 1'b0;
  endtask

  // next boundary: new code, then the period just ended
  task automatic period_check(int prev, int exp);
    int i;
    i = 0;
    while (slot_strobe_out !== 1'b1 && i < P + 100) begin
      @(negedge clk_in);
      i++;
    end
    chk("strobe", {31'h0, slot_strobe_out}, 32'h1);
    chk("duty", {22'h0, duty_code_out}, 32'(exp));
    repeat (3) @(negedge clk_in);
    chk("high", high_cyc, 32'((2 * prev + 1) * H));
    chk("period", per_cyc, 32'(P));
    chk("code", code_seen, 32'(prev));
    chk("current", ma_seen, 32'(22 * 1000 * (prev - 512) / 10240));
  endtask

  task automatic t_reset;
    chk("pwm rst", {31'h0, pwm_out}, 32'h0);
    chk("duty rst", {22'h0, duty_code_out}, 32'h200);
    chk("strobe rst", {31'h0, slot_strobe_out}, 32'h0);
  endtask

  task automatic t_clamp;
    feed(2048, 4000, 200);
    chk("duty held", {22'h0, duty_code_out}, 32'h200);
    period_check(512, 978);
  endtask

  task automatic t_neg_full;
    feed(-2048, -2048, 300);
    chk("duty held", {22'h0, duty_code_out}, 32'(978));
    period_check(978, 46);
  endtask

  task automatic t_average;
    feed(100, 300, 500);
    period_check(46, 557);
  endtask

  task automatic t_empty;
    period_check(557, 557);
    chk("avg2", avg2_seen, 32'(301));
  endtask

  initial begin
    repeat (8) @(negedge clk_in);
    t_reset();
    nrst_in = 1'b1;
    t_clamp();
    t_neg_full();
    t_average();
    t_empty();
    tally_and_finish();
  end

  initial begin
    repeat (6 * P + 1000) @(posedge clk_in);
    errors++;
    tally_and_finish();
  end
endmodule // current_sample_pwm_encoder_tb_top
